// File: spa_map.svh
// Named constants for the setpoint output block: value limits, timing.
// Assumes inclusion by name from the package and the top module.
`ifndef SPA_MAP_SVH
`define SPA_MAP_SVH

// Value ranges in display counts; delay range in tenth-second ticks
`define SPA_VALUE_W        18
`define SPA_CALC_W         20
`define SPA_SP_MIN         (20'shF_B1E1)
`define SPA_SP_MAX         (20'sh1_869F)
`define SPA_HYST_W         16
`define SPA_HYST_MIN       16'h0001
`define SPA_HYST_MAX       16'hEA5F
`define SPA_DELAY_W        13
`define SPA_DELAY_MAX      13'h176F

// Timing: delay tick of one tenth second
`define SPA_CLK_PERIOD_NS  20
`define SPA_TICK_NS        100_000_000
`define SPA_TICK_CYCLES    (`SPA_TICK_NS / `SPA_CLK_PERIOD_NS)
`define SPA_PRESCALE_W     23

// Number of setpoint channels
`define SPA_CHANNELS       2

`endif

// File: spa_pkg.sv
// Types shared by the setpoint output block.
// Assumes spa_map.svh is on the include path.
`default_nettype none
`include "spa_map.svh"

package spa_pkg;
  // Output reset action, one per channel
  typedef enum logic [1:0] {
    SPA_RESET_AUTO          = 2'h0,
    SPA_RESET_LATCH_IMMED   = 2'h1,
    SPA_RESET_LATCH_DELAYED = 2'h3
  } spa_reset_mode_type;
endpackage
`default_nettype wire

// File: spa_setpoint_alarm.sv
// Two-channel setpoint output logic for a temperature panel meter.
// Assumes the measured value, configuration and reset pulses are
// synchronous to CLOCK and the value uses the display's own scaling.
`timescale 1ns/100ps
`default_nettype none
`include "spa_map.svh"

module spa_setpoint_alarm
  import spa_pkg::*;
#(
  parameter int TICK_CYCLES = `SPA_TICK_CYCLES
) (
  input  wire logic                                    CLOCK,
  input  wire logic                                    RST_N,
  input  wire logic signed [`SPA_VALUE_W-1:0]          MEAS_VALUE,
  input  wire logic                                    PROBE_FAIL,
  input  wire logic                                    OUT_RESET_PULSE,
  input  wire logic                                    DISP_RESET_PULSE,
  input  wire logic                                    DISP_RESET_SOURCE_OK,
  input  wire logic                                    INPUT_SHOWN,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_ENABLE,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_HIGH_ACTING,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_BALANCED,
  input  wire logic [`SPA_CHANNELS-1:0][`SPA_VALUE_W-1:0] SP_VALUE,
  input  wire logic [`SPA_CHANNELS-1:0][`SPA_HYST_W-1:0]  SP_HYST,
  input  wire logic [`SPA_CHANNELS-1:0][`SPA_DELAY_W-1:0] SP_ON_DELAY,
  input  wire logic [`SPA_CHANNELS-1:0][`SPA_DELAY_W-1:0] SP_OFF_DELAY,
  input  wire logic [`SPA_CHANNELS-1:0][1:0]           SP_RESET_MODE,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_RESET_WITH_DISPLAY,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_STANDBY,
  input  wire logic [`SPA_CHANNELS-1:0]                SP_BURNOUT_ON,
  output logic      [`SPA_CHANNELS-1:0]                SP_OUTPUT,
  output logic      [`SPA_CHANNELS-1:0]                SP_RESET_PENDING
);

  // ----------------------------------------------------------------
  // Parameter check and shared tenth-second tick
  // ----------------------------------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << `SPA_PRESCALE_W)) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  localparam logic [`SPA_PRESCALE_W-1:0] TICK_LAST = `SPA_PRESCALE_W'(TICK_CYCLES - 1);

  logic [`SPA_PRESCALE_W-1:0] prescale;
  logic [`SPA_PRESCALE_W-1:0] next_prescale;
  logic                       tick;
  logic                       next_tick;

  // One tick pulse per tenth of a second
  always_comb begin
    next_tick     = (prescale == TICK_LAST);
    next_prescale = next_tick ? '0 : prescale + `SPA_PRESCALE_W'(1);
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      prescale <= '0;
      tick     <= 1'b0;
    end else begin
      prescale <= next_prescale;
      tick     <= next_tick;
    end
  end

  // ----------------------------------------------------------------
  // Qualified display reset, common to both channels
  // ----------------------------------------------------------------
  logic disp_reset_ok;

  assign disp_reset_ok = DISP_RESET_PULSE && DISP_RESET_SOURCE_OK && INPUT_SHOWN;

  // ----------------------------------------------------------------
  // Setpoint channels
  // ----------------------------------------------------------------
  // independent channel instances
  for (genvar i = 0; i < `SPA_CHANNELS; i++) begin : g_ch
    logic signed [`SPA_CALC_W-1:0] meas;
    logic signed [`SPA_CALC_W-1:0] sp;
    logic signed [`SPA_CALC_W-1:0] hyst;
    logic signed [`SPA_CALC_W-1:0] half;
    logic signed [`SPA_CALC_W-1:0] rest;
    logic signed [`SPA_CALC_W-1:0] on_pt;
    logic signed [`SPA_CALC_W-1:0] off_pt;
    logic [`SPA_DELAY_W-1:0]       on_dly;
    logic [`SPA_DELAY_W-1:0]       off_dly;
    logic [`SPA_HYST_W-1:0]        hyst_in;
    spa_reset_mode_type            mode;
    logic                          on_cond;
    logic                          off_cond;
    logic                          on_eff;
    logic                          rst_eff;
    logic                          want;
    logic                          clear_now;
    logic                          delayed_clear;
    logic                          force_off;

    // Channel state and next values
    logic                    state_on;
    logic                    demand;
    logic                    supp;
    logic                    hold;
    logic                    pending;
    logic [`SPA_DELAY_W-1:0] cnt;
    logic                    next_state_on;
    logic                    next_demand;
    logic                    next_supp;
    logic                    next_hold;
    logic                    next_pending;
    logic [`SPA_DELAY_W-1:0] next_cnt;
    logic                    next_out;

    // Switching points; values arrive in display counts
    always_comb begin
      meas = `SPA_CALC_W'(MEAS_VALUE);
      sp   = `SPA_CALC_W'($signed(SP_VALUE[i]));
      if (sp < `SPA_SP_MIN) sp = `SPA_SP_MIN;
      if (sp > `SPA_SP_MAX) sp = `SPA_SP_MAX;
      hyst_in = SP_HYST[i];
      if (hyst_in < `SPA_HYST_MIN) hyst_in = `SPA_HYST_MIN;
      if (hyst_in > `SPA_HYST_MAX) hyst_in = `SPA_HYST_MAX;
      hyst = $signed({4'h0, hyst_in});
      half = $signed({5'h0, hyst_in[`SPA_HYST_W-1:1]});
      rest = hyst - half;
      on_dly  = (SP_ON_DELAY[i] > `SPA_DELAY_MAX) ? `SPA_DELAY_MAX : SP_ON_DELAY[i];
      off_dly = (SP_OFF_DELAY[i] > `SPA_DELAY_MAX) ? `SPA_DELAY_MAX : SP_OFF_DELAY[i];
      if (SP_BALANCED[i]) begin
        on_pt  = SP_HIGH_ACTING[i] ? sp + half : sp - half;
        off_pt = SP_HIGH_ACTING[i] ? sp - rest : sp + rest;
      end else begin
        on_pt  = sp;
        off_pt = SP_HIGH_ACTING[i] ? sp - hyst : sp + hyst;
      end
      on_cond  = SP_HIGH_ACTING[i] ? (meas >= on_pt) : (meas <= on_pt);
      off_cond = SP_HIGH_ACTING[i] ? (meas <= off_pt) : (meas >= off_pt);
    end

    // Mode decode, standby gate and reset sources
    always_comb begin
      mode = spa_reset_mode_type'(SP_RESET_MODE[i]);
      on_eff = on_cond && !(SP_STANDBY[i] && hold);
      rst_eff = OUT_RESET_PULSE || (disp_reset_ok && SP_RESET_WITH_DISPLAY[i]);
      clear_now = rst_eff && (mode != SPA_RESET_LATCH_DELAYED);
      // remembered reset fires at off point
      delayed_clear = (mode == SPA_RESET_LATCH_DELAYED) && pending && off_cond;
      force_off = clear_now || delayed_clear;
      if (mode == SPA_RESET_AUTO) begin
        want = demand && !supp;
      end else begin
        want = (state_on || on_eff) && !supp;
      end
    end

    // Next state of the channel
    always_comb begin
      next_demand   = demand;
      next_supp     = supp;
      next_hold     = hold;
      next_pending  = pending;
      next_state_on = state_on;
      next_cnt      = cnt;
      if (on_eff) begin
        next_demand = 1'b1;
      end else if (off_cond) begin
        next_demand = 1'b0;
      end
      // Standby ends once the inactive side is seen
      if (off_cond) begin
        next_hold = 1'b0;
      end
      // Set wins over the clear by the off point
      if (clear_now) begin
        next_supp = 1'b1;
      end else if (off_cond) begin
        next_supp = 1'b0;
      end
      if (rst_eff && state_on && mode == SPA_RESET_LATCH_DELAYED) begin
        next_pending = 1'b1;
      end else if (delayed_clear || mode != SPA_RESET_LATCH_DELAYED) begin
        next_pending = 1'b0;
      end
      if (force_off) begin
        next_state_on = 1'b0;
        next_cnt      = '0;
      end else if (want == state_on) begin
        next_cnt = '0;
      end else if (cnt >= (state_on ? off_dly : on_dly)) begin
        next_state_on = want;
        next_cnt      = '0;
      end else if (tick) begin
        next_cnt = cnt + `SPA_DELAY_W'(1);
      end
      if (!SP_ENABLE[i]) begin
        next_state_on = 1'b0;
        next_demand   = 1'b0;
        next_supp     = 1'b0;
        next_pending  = 1'b0;
        next_cnt      = '0;
      end
      if (!SP_ENABLE[i]) begin
        next_out = 1'b0;
      end else if (PROBE_FAIL) begin
        next_out = SP_BURNOUT_ON[i];
      end else begin
        next_out = next_state_on;
      end
    end

    // power up starts off, standby armed
    always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
        state_on            <= 1'b0;
        demand              <= 1'b0;
        supp                <= 1'b0;
        hold                <= 1'b1;
        pending             <= 1'b0;
        cnt                 <= '0;
        SP_OUTPUT[i]        <= 1'b0;
        SP_RESET_PENDING[i] <= 1'b0;
      end else begin
        state_on            <= next_state_on;
        demand              <= next_demand;
        supp                <= next_supp;
        hold                <= next_hold;
        pending             <= next_pending;
        cnt                 <= next_cnt;
        SP_OUTPUT[i]        <= next_out;
        SP_RESET_PENDING[i] <= next_pending;
      end
    end

    // --------------------------------------------------------------
    // Checks on channel behaviour
    // --------------------------------------------------------------
    a_disabled_off: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !SP_ENABLE[i] |=> !SP_OUTPUT[i] && !state_on)
      else $error("disabled setpoint drove output");

    a_burnout_state: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && PROBE_FAIL |=> SP_OUTPUT[i] == $past(SP_BURNOUT_ON[i]))
      else $error("burn-out state not applied");

    a_on_held_off: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && !state_on && want && cnt < on_dly |=> !state_on)
      else $error("output turned on before on delay");

    a_zero_on_delay: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && !state_on && want && !force_off && on_dly == '0 |=> state_on)
      else $error("zero on delay not immediate");

    a_off_held_on: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && state_on && !want && !force_off && cnt < off_dly |=> state_on)
      else $error("output turned off before off delay");

    a_manual_clear: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && rst_eff && mode != SPA_RESET_LATCH_DELAYED |=> !state_on ##1 !state_on)
      else $error("manual reset did not clear output");

    a_latch_keeps: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && mode == SPA_RESET_LATCH_IMMED && state_on && !rst_eff |=> state_on)
      else $error("latched output dropped without reset");

    a_delayed_pend: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && mode == SPA_RESET_LATCH_DELAYED && rst_eff && state_on && !off_cond
      |=> pending && state_on)
      else $error("delayed reset not remembered");

    a_display_gate: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      !OUT_RESET_PULSE && !(DISP_RESET_SOURCE_OK && INPUT_SHOWN) |-> !rst_eff)
      else $error("display reset acted while unqualified");

    a_standby_hold: assert property (
      @(posedge CLOCK) disable iff (!RST_N)
      SP_ENABLE[i] && SP_STANDBY[i] && hold && !state_on && !demand |=> !state_on && !demand)
      else $error("standby output turned on");
  end

endmodule
`default_nettype wire

// File: spa_front_model.sv
// Behavioural measurement channel and front panel reset sources.
// Assumes the bench changes its requests shortly after clock rises.
`timescale 1ns/100ps
`default_nettype none
`include "spa_map.svh"

module spa_front_model (
  input  wire logic                          clock,
  input  wire logic signed [`SPA_VALUE_W-1:0] req_meas,
  input  wire logic                          req_fail,
  input  wire logic                          req_key,
  input  wire logic                          req_disp,
  output var  logic signed [`SPA_VALUE_W-1:0] meas_value,
  output var  logic                          probe_fail,
  output var  logic                          out_reset_pulse,
  output var  logic                          disp_reset_pulse
);
  logic key_prev;
  logic disp_prev;

  // Defined levels from time zero
  initial begin
    meas_value = '0;
    probe_fail = 1'b0;
    out_reset_pulse = 1'b0;
    disp_reset_pulse = 1'b0;
    key_prev = 1'b0;
    disp_prev = 1'b0;
  end

  // ----------------------------------------
  // Reading and key presses, one clock late
  // ----------------------------------------
  // broken probe
  always @(posedge clock) begin
    probe_fail <= req_fail;
    meas_value <= req_fail ? ~meas_value : req_meas;  // Dead sensor: no steady reading
    key_prev <= req_key;
    disp_prev <= req_disp;
    out_reset_pulse <= req_key & ~key_prev;  // Key held long still gives one pulse
    disp_reset_pulse <= req_disp & ~disp_prev;
  end
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the two-channel setpoint output block.
// Assumes a short delay tick so that timed cases stay brief.
`timescale 1ns/100ps
`default_nettype none
`include "spa_map.svh"

module tb import spa_pkg::*;;
  // ----------------------------------------
  // Stimulus state and tables
  // ----------------------------------------
  localparam int TICK = 4;
  localparam logic [17:0] S1 = 18'h0_0064;
  localparam logic [15:0] H1 = 16'h000A;
  localparam logic [17:0] S2 = 18'h1_869F;
  localparam logic [15:0] H2 = 16'hEA5F;
  localparam logic [17:0] S3 = 18'h3_B1E1;
  localparam logic [15:0] H3 = 16'h0001;
  typedef struct packed {
    logic        hi;
    logic        bal;
    logic [17:0] sp;
    logic [15:0] h;
    logic [17:0] m;
    logic        e;
  } spa_row_type;
  spa_row_type rows [29] = '{
    '{1,0,S1,H1,18'h0_0050,0}, '{1,0,S1,H1,18'h0_0063,0}, '{1,0,S1,H1,18'h0_0064,1},
    '{1,0,S1,H1,18'h0_005B,1}, '{1,0,S1,H1,18'h0_005A,0}, '{1,1,S1,H1,18'h0_0050,0},
    '{1,1,S1,H1,18'h0_0068,0}, '{1,1,S1,H1,18'h0_0069,1}, '{1,1,S1,H1,18'h0_0060,1},
    '{1,1,S1,H1,18'h0_005F,0}, '{0,0,S1,H1,18'h0_0078,0}, '{0,0,S1,H1,18'h0_0065,0},
    '{0,0,S1,H1,18'h0_0064,1}, '{0,0,S1,H1,18'h0_006D,1}, '{0,0,S1,H1,18'h0_006E,0},
    '{0,1,S1,H1,18'h0_0078,0}, '{0,1,S1,H1,18'h0_0060,0}, '{0,1,S1,H1,18'h0_005F,1},
    '{0,1,S1,H1,18'h0_0068,1}, '{0,1,S1,H1,18'h0_0069,0}, '{1,0,S2,H2,18'h0_9C40,0},
    '{1,0,S2,H2,18'h1_869E,0}, '{1,0,S2,H2,18'h1_869F,1}, '{1,0,S2,H2,18'h0_9C41,1},
    '{1,0,S2,H2,18'h0_9C40,0}, '{0,0,S3,H3,18'h0_0000,0}, '{0,0,S3,H3,18'h3_B1E2,0},
    '{0,0,S3,H3,18'h3_B1E1,1}, '{0,0,S3,H3,18'h3_B1E2,0}};
  logic                     clock = 1'b0;
  logic                     rst_n = 1'b0;
  logic signed [17:0]       req_meas = 18'h0_005A;
  logic                     req_fail = 1'b0, req_key = 1'b0, req_disp = 1'b0;
  logic                     src_ok = 1'b0, shown = 1'b0;
  logic [1:0]               en = 2'h1, hi = 2'h3, bal = 2'h0, rwd = 2'h0, stby = 2'h0, bo = 2'h0;
  logic [1:0][17:0]         sp = '0;
  logic [1:0][15:0]         hy = {H1, H1};
  logic [1:0][12:0]         ond = '0, offd = '0;
  logic [1:0][1:0]          mode = '0;
  wire signed [17:0]        meas;
  wire                      fail, key_pulse, disp_pulse;
  wire [1:0]                out, pend;
  int                       bad_count = 0, samples_checked = 0, n;

  always #10 clock = ~clock;

  spa_front_model front (.clock(clock), .req_meas(req_meas), .req_fail(req_fail),
    .req_key(req_key), .req_disp(req_disp), .meas_value(meas), .probe_fail(fail),
    .out_reset_pulse(key_pulse), .disp_reset_pulse(disp_pulse));

  spa_setpoint_alarm #(.TICK_CYCLES(TICK)) dut (.CLOCK(clock), .RST_N(rst_n),
    .MEAS_VALUE(meas), .PROBE_FAIL(fail), .OUT_RESET_PULSE(key_pulse),
    .DISP_RESET_PULSE(disp_pulse), .DISP_RESET_SOURCE_OK(src_ok), .INPUT_SHOWN(shown),
    .SP_ENABLE(en), .SP_HIGH_ACTING(hi), .SP_BALANCED(bal), .SP_VALUE(sp), .SP_HYST(hy),
    .SP_ON_DELAY(ond), .SP_OFF_DELAY(offd), .SP_RESET_MODE(mode),
    .SP_RESET_WITH_DISPLAY(rwd), .SP_STANDBY(stby), .SP_BURNOUT_ON(bo),
    .SP_OUTPUT(out), .SP_RESET_PENDING(pend));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Inputs always move the same 2 ns after the edge
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask
  // Model adds a cycle, so four edges covers the response
  task automatic settle();
    step(4);
  endtask
  task automatic press(input logic disp);
    if (disp) req_disp = 1'b1;
    else req_key = 1'b1;
    settle();
    req_disp = 1'b0;
    req_key = 1'b0;
    step(1);
  endtask
  task automatic wait_out(input logic v, output int cnt);
    cnt = 0;
    while (out[0] !== v && cnt < 300) begin
      step(1);
      cnt++;
    end
    if (cnt >= 300) begin
      bad_count++;
      $display("FAIL %0t output never settled", $time);
      wrap_up();
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    step(3);
    chk({pend, out}, 4'h0);
    rst_n = 1'b1;
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    step(0);
    do_reset();
    // Actions, bands and limits; channel 1 would trip if enabled
    foreach (rows[i]) begin
      hi[0] = rows[i].hi;
      bal[0] = rows[i].bal;
      sp[0] = rows[i].sp;
      hy[0] = rows[i].h;
      req_meas = rows[i].m;
      settle();
      chk(out[0], rows[i].e);
      chk(out[1], 1'b0);
    end
    // Delays, with a dropout that restarts the on timer
    hi[0] = 1'b1;
    bal[0] = 1'b0;
    sp[0] = S1;
    hy[0] = H1;
    ond[0] = 13'h0005;
    offd[0] = 13'h0002;
    req_meas = 18'h0_005A;
    settle();
    req_meas = 18'h0_0064;
    step(14);
    chk(out[0], 1'b0);
    // Dropout must reach the off point; inside the band the demand holds
    req_meas = 18'h0_005A;
    step(2);
    req_meas = 18'h0_0064;
    wait_out(1'b1, n);
    chk(n >= 4 * TICK && n <= 6 * TICK + 6, 1'b1);
    req_meas = 18'h0_005A;
    wait_out(1'b0, n);
    chk(n >= 6 && n <= 3 * TICK + 6, 1'b1);
    ond[0] = '0;
    offd[0] = '0;
    // Manual reset in automatic mode
    req_meas = 18'h0_0064;
    settle();
    press(1'b0);
    chk(out[0], 1'b0);
    step(6);
    chk(out[0], 1'b0);
    req_meas = 18'h0_005A;
    settle();
    req_meas = 18'h0_0064;
    settle();
    chk(out[0], 1'b1);
    // Immediate latch holds below the off point
    mode[0] = SPA_RESET_LATCH_IMMED;
    req_meas = 18'h0_0050;
    settle();
    chk(out[0], 1'b1);
    press(1'b0);
    chk(out[0], 1'b0);
    req_meas = 18'h0_0064;
    settle();
    chk(out[0], 1'b1);
    // Display reset acts only with all three qualifiers
    for (int i = 0; i < 8; i++) begin
      {rwd[0], src_ok, shown} = i[2:0];
      press(1'b1);
      chk(out[0], i == 7 ? 1'b0 : 1'b1);
    end
    // Delayed latch reset waits for the off point
    mode[0] = SPA_RESET_LATCH_DELAYED;
    req_meas = 18'h0_005A;
    settle();
    for (int k = 0; k < 2; k++) begin
      req_meas = 18'h0_0064;
      settle();
      req_meas = 18'h0_005F;
      press(1'b0);
      chk({pend[0], out[0]}, 2'h3);
      if (k == 0) req_meas = 18'h0_005A;
      else do_reset();
      settle();
      chk({pend[0], out[0]}, 2'h0);
    end
    // Standby after power up
    mode[0] = SPA_RESET_AUTO;
    stby[0] = 1'b1;
    req_meas = 18'h0_0064;
    do_reset();
    settle();
    chk(out[0], 1'b0);
    req_meas = 18'h0_005A;
    settle();
    req_meas = 18'h0_0064;
    settle();
    chk(out[0], 1'b1);
    // Probe failure and two independent channels
    en = 2'h3;
    hi[1] = 1'b0;
    for (int k = 1; k < 3; k++) begin
      bo = k[1:0];
      req_fail = 1'b1;
      settle();
      chk(out, bo);
    end
    req_fail = 1'b0;
    settle();
    chk(out, 2'h1);
    req_meas = 18'h3_FFF6;
    settle();
    chk(out, 2'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
